// ==== design/rsc_top.sv ====
// Purpose: Reset sequencer with stop recovery and cause register
// Assumes: mclk 10 MHz; oscillator and system ticks are mclk enables
// Notes:   Register slave answers every transfer after one wait state
`timescale 1ns/1ns

module rsc_top
	import rsc_pkg::*;
(
	// Clock and reset
	input  wire logic              mclk,
	input  wire logic              reset,
	// AHB-Lite slave
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic      [31:0]       hrdata,
	output logic                   hreadyout,
	output logic                   hresp,
	// Analog monitors and asynchronous sources
	input  wire logic              por_det,
	input  wire logic              brownout_low,
	input  wire logic              wdt_timeout,
	input  wire logic              fault_det,
	input  wire logic [GPIO_W-1:0] gpio_pin,
	// Reset pin, open drain
	input  wire logic              reset_pin_i,
	output logic                   reset_pin_o,
	output logic                   reset_pin_oe_n,
	// Core status and option bits
	input  wire logic              stop_mode,
	input  wire logic              watchdog_reset_option,
	input  wire logic              brownout_in_stop_option,
	input  wire logic              fltsel_option,
	input  wire logic [PWM_W-1:0]  pwm_off_option,
	// Controls to core and peripherals
	output logic                   cpu_reset,
	output logic                   periph_reset,
	output logic                   debugger_reset,
	output logic                   option_load,
	output logic                   sysclk_en,
	output logic                   gpio_input_force,
	output logic                   pwm_hiz,
	output logic                   pwm_drive_off,
	output logic      [PWM_W-1:0]  pwm_off_level,
	output logic                   brownout_enable,
	output logic                   fault0_in,
	output logic                   vector_fetch,
	output logic      [15:0]       vector_addr
);
	rsc_sync_if sy ();

	rsc_state_type   st_q, st_d;
	logic            sys_kind_q, dbg_kind_q;
	logic [6:0]      tot_q;
	logic [6:0]      opt_q;
	logic [4:0]      sys_q;
	logic [3:0]      osc_div_q, sys_div_q;
	logic [2:0]      pin_cnt_q;
	logic            pin_ok_q, pin_prev_q, wdt_prev_q, flt_prev_q;
	logic [GPIO_W-1:0] gpio_prev_q, rcv_en_q;
	logic [7:0]      cause_q;
	logic [1:0]      lock_q;
	logic            dbg_rst_q;
	logic            pend_q, pend_wr_q;
	logic [11:0]     pend_idx_q;
	logic [31:0]     hrdata_q;
	logic            hreadyout_q;
	logic            cpu_rst_q, per_rst_q, dbg_rst_out_q, optld_q, sclk_q;
	logic            gpio_f_q, pwm_hiz_q, pwm_off_q, pin_oe_n_q, bo_en_q;
	logic            fault0_q, vfetch_q;
	logic [PWM_W-1:0] pwm_lvl_q;

	// Input synchroniser
	// Own pin drive is masked so it never reads back as a request
	assign sy.raw = {gpio_pin, fault_det, ~reset_pin_i & pin_oe_n_q,
		wdt_timeout, brownout_low, por_det};
	rsc_sync u_sync (
		.mclk  (mclk),
		.reset (reset),
		.sy    (sy)
	);

	// Tick enables
	wire osc_tick = (osc_div_q == OSC_DIV - 4'd1);
	wire sys_tick = (sys_div_q == SYS_DIV - 4'd1);

	// Request decode
	wire fltsel     = cause_q[FLTSEL_BIT];
	wire bo_active  = sy.clean[SY_BO] & (~stop_mode
		| brownout_in_stop_option);
	wire pwr_req    = sy.clean[SY_POR] | bo_active;
	wire pin_low    = sy.clean[SY_PIN] & ~fltsel;
	wire pin_qual   = pin_low & (pin_cnt_q == PIN_QUAL_CYC);
	wire pin_ev     = pin_qual & ~pin_ok_q & (st_q != ST_SYS);
	wire wdt_ev     = sy.clean[SY_WDT] & ~wdt_prev_q;
	wire flt_ev     = sy.clean[SY_FLT] & ~flt_prev_q;
	wire wdt_sys    = wdt_ev & watchdog_reset_option & ~stop_mode;
	wire [GPIO_W-1:0] gpio_chg = (sy.clean[SY_GPIO +: GPIO_W]
		^ gpio_prev_q) & rcv_en_q;
	wire smr_req    = stop_mode & (wdt_ev | (|gpio_chg));
	wire sys_req    = pwr_req | wdt_sys | pin_ev | flt_ev
		| (dbg_rst_q & ~stop_mode);
	wire any_req    = sys_req | smr_req;
	wire start      = any_req;
	wire dbg_only   = dbg_rst_q & ~(pwr_req | wdt_sys | pin_ev | flt_ev);

	// New cause bits; power events win outright
	function automatic logic [7:0] cause_of(input logic pwr,
		input logic dbg, input logic wdt, input logic pin,
		input logic fault_cause_bit, input logic stop_recovery, input logic keep);
		logic [7:0] c;
		c = '0;
		c[FLTSEL_BIT] = keep;
		if (pwr) begin
			c[CAUSE_POR_BIT] = 1'b1;
		end else begin
			c[CAUSE_POR_BIT]  = dbg;
			c[CAUSE_STOP_BIT] = stop_recovery;
			c[CAUSE_WDT_BIT]  = wdt;
			c[CAUSE_EXT_BIT]  = pin;
			c[CAUSE_FLT_BIT]  = fault_cause_bit;
		end
		return c;
	endfunction

	wire [7:0] new_cause = cause_of(pwr_req, dbg_rst_q & ~stop_mode,
		wdt_ev & (stop_mode | watchdog_reset_option), pin_ev, flt_ev,
		smr_req & ~sys_req, fltsel);

	// Sequence state
	wire opt_done = (opt_q == OPT_LOAD_CYC);
	wire sys_done = (sys_q == SYS_TAIL_CYC) & (tot_q >= OSC_HOLD_CYC);
	always_comb begin
		st_d = st_q;
		case (st_q)
			ST_RUN:  if (start) st_d = ST_LOAD;
			ST_LOAD: if (start) st_d = ST_LOAD;
				else if (opt_done) st_d = ST_SYS;
			ST_SYS:  if (start) st_d = ST_LOAD;
				else if (sys_done) st_d = ST_RUN;
			default: st_d = ST_RUN;
		endcase
	end
	wire in_seq   = (st_d != ST_RUN);
	wire sys_seq  = in_seq & (start ? sys_req : sys_kind_q);
	wire pin_hold = pin_low & (st_q == ST_SYS);

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			st_q       <= ST_LOAD;
			sys_kind_q <= 1'b1;
			dbg_kind_q <= 1'b0;
			tot_q      <= '0;
			opt_q      <= '0;
			sys_q      <= '0;
		end else begin
			st_q <= st_d;
			if (start) begin
				sys_kind_q <= sys_req;
				dbg_kind_q <= dbg_only;
				// Start cycle is the first counted cycle
				tot_q      <= 7'd1;
				opt_q      <= 7'd1;
				sys_q      <= '0;
			end else begin
				if (osc_tick && tot_q != OSC_HOLD_CYC)
					tot_q <= tot_q + 7'd1;
				if (osc_tick && st_q == ST_LOAD && !opt_done)
					opt_q <= opt_q + 7'd1;
				if (pin_hold)
					sys_q <= '0;
				else if (sys_tick && st_d == ST_SYS && sys_q != SYS_TAIL_CYC)
					sys_q <= sys_q + 5'd1;
			end
		end
	end

	// Dividers, pin filter and edge history
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			osc_div_q   <= '0;
			sys_div_q   <= '0;
			pin_cnt_q   <= '0;
			pin_ok_q    <= 1'b0;
			wdt_prev_q  <= 1'b0;
			flt_prev_q  <= 1'b0;
			gpio_prev_q <= '0;
		end else begin
			osc_div_q <= osc_tick ? 4'd0 : osc_div_q + 4'd1;
			sys_div_q <= sys_tick ? 4'd0 : sys_div_q + 4'd1;
			if (!pin_low)
				pin_cnt_q <= '0;
			else if (sys_tick && pin_cnt_q != PIN_QUAL_CYC)
				pin_cnt_q <= pin_cnt_q + 3'd1;
			pin_ok_q    <= pin_qual;
			wdt_prev_q  <= sy.clean[SY_WDT];
			flt_prev_q  <= sy.clean[SY_FLT];
			gpio_prev_q <= sy.clean[SY_GPIO +: GPIO_W];
		end
	end

	// Register access
	wire acc     = hsel & htrans[1] & hready;
	wire [11:0] a_idx = haddr[ADDR_W-1:2];
	wire wr_now  = pend_q & pend_wr_q;
	wire [7:0] wb = hwdata[7:0];
	wire wr_cause = wr_now & (pend_idx_q == CAUSE_INDEX);
	wire wr_dbg   = wr_now & (pend_idx_q == DBGCTL_INDEX);
	wire wr_rcv   = wr_now & (pend_idx_q == RCVEN_INDEX);
	wire [7:0] rd_mux = (pend_idx_q == CAUSE_INDEX)  ? cause_q :
		(pend_idx_q == DBGCTL_INDEX) ? {7'd0, dbg_rst_q} :
		(pend_idx_q == RCVEN_INDEX)  ? rcv_en_q : 8'h00;

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			pend_q      <= 1'b0;
			pend_wr_q   <= 1'b0;
			pend_idx_q  <= '0;
			hrdata_q    <= '0;
			hreadyout_q <= 1'b1;
		end else begin
			pend_q      <= acc & ~pend_q;
			pend_wr_q   <= hwrite;
			pend_idx_q  <= a_idx;
			hreadyout_q <= ~(acc & ~pend_q);
			if (pend_q && !pend_wr_q)
				hrdata_q <= {24'd0, rd_mux};
		end
	end

	// Cause, unlock, debugger request and recovery enables
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			cause_q   <= CAUSE_RESET;
			lock_q    <= '0;
			dbg_rst_q <= 1'b0;
			rcv_en_q  <= RCVEN_RESET;
		end else begin
			if (start)
				cause_q <= new_cause;
			else if (st_q == ST_LOAD && opt_done && sys_kind_q)
				cause_q[FLTSEL_BIT] <= fltsel_option;
			else if (wr_cause && lock_q == 2'd2)
				cause_q[FLTSEL_BIT] <= wb[FLTSEL_BIT];
			if (wr_cause)
				lock_q <= (lock_q == 2'd0 && wb == UNLOCK_KEY1) ? 2'd1 :
					(lock_q == 2'd1 && wb == UNLOCK_KEY2) ? 2'd2 : 2'd0;
			if (wr_dbg && wb[DBG_RST_BIT])
				dbg_rst_q <= 1'b1;
			else if (start && !stop_mode)
				dbg_rst_q <= 1'b0;
			else if (wr_dbg)
				dbg_rst_q <= 1'b0;
			if (sys_seq)
				rcv_en_q <= RCVEN_RESET;
			else if (wr_rcv)
				rcv_en_q <= wb;
		end
	end

	// Reset outputs
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			cpu_rst_q     <= 1'b1;
			per_rst_q     <= 1'b1;
			dbg_rst_out_q <= 1'b1;
			optld_q       <= 1'b1;
			sclk_q        <= 1'b0;
			gpio_f_q      <= 1'b1;
			pwm_hiz_q     <= 1'b1;
			pwm_off_q     <= 1'b0;
			pwm_lvl_q     <= '0;
			pin_oe_n_q    <= 1'b0;
			bo_en_q       <= 1'b1;
			fault0_q      <= 1'b0;
			vfetch_q      <= 1'b0;
		end else begin
			cpu_rst_q     <= in_seq;
			per_rst_q     <= sys_seq;
			dbg_rst_out_q <= sys_seq & ~(start ? dbg_only : dbg_kind_q);
			optld_q       <= st_d == ST_LOAD;
			sclk_q        <= st_d != ST_LOAD;
			gpio_f_q      <= sys_seq;
			pwm_hiz_q     <= sys_seq & st_d == ST_LOAD;
			pwm_off_q     <= sys_seq & st_d == ST_SYS;
			if (st_q == ST_LOAD && opt_done)
				pwm_lvl_q <= pwm_off_option;
			pin_oe_n_q    <= ~(sys_seq & st_d == ST_LOAD);
			bo_en_q       <= ~stop_mode | brownout_in_stop_option;
			fault0_q      <= fltsel & sy.clean[SY_PIN];
			vfetch_q      <= st_q == ST_SYS && st_d == ST_RUN;
		end
	end

	assign hrdata           = hrdata_q;
	assign hreadyout        = hreadyout_q;
	assign hresp            = 1'b0;
	assign reset_pin_o      = 1'b0;
	assign reset_pin_oe_n   = pin_oe_n_q;
	assign cpu_reset        = cpu_rst_q;
	assign periph_reset     = per_rst_q;
	assign debugger_reset   = dbg_rst_out_q;
	assign option_load      = optld_q;
	assign sysclk_en        = sclk_q;
	assign gpio_input_force = gpio_f_q;
	assign pwm_hiz          = pwm_hiz_q;
	assign pwm_drive_off    = pwm_off_q;
	assign pwm_off_level    = pwm_lvl_q;
	assign brownout_enable  = bo_en_q;
	assign fault0_in        = fault0_q;
	assign vector_fetch     = vfetch_q;
	assign vector_addr      = VECTOR_ADDR;

	// Checks
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);

	sequence release_seq;
		$fell(cpu_rst_q);
	endsequence

	chk_hold_min_osc: assert property (release_seq |-> $past(tot_q)
		>= OSC_HOLD_CYC) else $error("released before 66 cycles");
	chk_opt_before_clk: assert property ($rose(sclk_q) |->
		$past(opt_q) == OPT_LOAD_CYC) else $error("clock before load");
	chk_sys_tail_count: assert property (release_seq |->
		$past(sys_q) == SYS_TAIL_CYC) else $error("tail not 16");
	chk_release_fetch: assert property (release_seq |-> vfetch_q)
		else $error("no vector fetch on release");
	chk_pin_drive: assert property (per_rst_q |-> pin_oe_n_q == !optld_q)
		else $error("reset pin not driven");
	chk_gpio_safe: assert property ($rose(per_rst_q) |-> gpio_f_q
		&& pwm_hiz_q) else $error("pins unsafe at reset");
	chk_power_prio: assert property (start && pwr_req |=>
		cause_q[7:3] == 5'b10000) else $error("power cause lost");
	chk_dbg_clear: assert property (start && !stop_mode && !wr_dbg |=>
		!dbg_rst_q) else $error("debug request stuck");
	chk_stop_keep: assert property (start && !sys_req |=> !per_rst_q
		&& cause_q[CAUSE_STOP_BIT]) else $error("stop recovery bad");
	chk_bo_hold: assert property (pwr_req |=> cpu_rst_q && st_q ==
		ST_LOAD) else $error("brown-out not held");
endmodule // rsc_top

// ==== design/rsc_pkg.sv ====
// Purpose: Shared constants for the reset and stop recovery controller
// Assumes: One clock, AHB-Lite register access with 32-bit data
// Notes:   Register indices are word indices; byte address is index * 4
package rsc_pkg;

	// Register indices and byte address width
	localparam logic [11:0] CAUSE_INDEX    = 12'hFF0;
	localparam logic [11:0] DBGCTL_INDEX   = 12'h001;
	localparam logic [11:0] RCVEN_INDEX    = 12'h002;
	localparam int          ADDR_W         = 14;

	// Cause register fields
	localparam int          CAUSE_POR_BIT  = 7;
	localparam int          CAUSE_STOP_BIT = 6;
	localparam int          CAUSE_WDT_BIT  = 5;
	localparam int          CAUSE_EXT_BIT  = 4;
	localparam int          CAUSE_FLT_BIT  = 3;
	localparam int          FLTSEL_BIT     = 0;
	localparam logic [7:0]  CAUSE_RESET    = 8'h80;
	localparam logic [7:0]  UNLOCK_KEY1    = 8'h14;
	localparam logic [7:0]  UNLOCK_KEY2    = 8'h92;

	// Debugger control and recovery enables
	localparam int          DBG_RST_BIT    = 0;
	localparam int          GPIO_W         = 8;
	localparam logic [7:0]  RCVEN_RESET    = 8'h00;

	// Sequence counts
	localparam logic [6:0]  OSC_HOLD_CYC   = 7'd66;
	localparam logic [6:0]  OPT_LOAD_CYC   = 7'd50;
	localparam logic [4:0]  SYS_TAIL_CYC   = 5'd16;
	localparam logic [2:0]  PIN_QUAL_CYC   = 3'd4;
	localparam logic [3:0]  OSC_DIV        = 4'd1;
	localparam logic [3:0]  SYS_DIV        = 4'd1;
	localparam logic [15:0] VECTOR_ADDR    = 16'h0002;
	localparam int          PWM_W          = 6;

	// Synchronised input bit positions
	localparam int          SY_POR         = 0;
	localparam int          SY_BO          = 1;
	localparam int          SY_WDT         = 2;
	localparam int          SY_PIN         = 3;
	localparam int          SY_FLT         = 4;
	localparam int          SY_GPIO        = 5;
	localparam int          SY_W           = SY_GPIO + GPIO_W;

	typedef enum logic [1:0] {ST_RUN, ST_LOAD, ST_SYS} rsc_state_type;

endpackage

// ==== design/rsc_sync_if.sv ====
// Purpose: Carrier between the controller and its input synchroniser
// Assumes: Raw inputs are asynchronous to mclk
// Notes:   Clean values are stable once stages two and three agree
`timescale 1ns/1ns
interface rsc_sync_if;
	import rsc_pkg::*;
	logic [SY_W-1:0] raw;
	logic [SY_W-1:0] clean;
	modport sync (input raw, output clean);
	modport user (output raw, input clean);
endinterface

// ==== design/rsc_sync.sv ====
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Raw inputs may change at any time
// Notes:   A change counts once stages two and three agree
`timescale 1ns/1ns
module rsc_sync
	import rsc_pkg::*;
(
	// Clock and reset
	input  wire logic mclk,
	input  wire logic reset,
	// Signals
	rsc_sync_if.sync  sy
);
	logic [SY_W-1:0] s1_q;
	logic [SY_W-1:0] s2_q;
	logic [SY_W-1:0] s3_q;
	logic [SY_W-1:0] clean_q;
	logic [SY_W-1:0] clean_d;
	logic [SY_W-1:0] agree;

	assign agree   = ~(s2_q ^ s3_q);
	assign clean_d = (agree & s3_q) | (~agree & clean_q);
	assign sy.clean = clean_q;

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			s1_q    <= '0;
			s2_q    <= '0;
			s3_q    <= '0;
			clean_q <= '0;
		end else begin
			s1_q    <= sy.raw;
			s2_q    <= s1_q;
			s3_q    <= s2_q;
			clean_q <= clean_d;
		end
	end
endmodule // rsc_sync

// ==== tb/rsc_core_model.sv ====
// Purpose: Far-side model of the core and the reset pin wire
// Assumes: Pin has a pull-up; core drives stop_mode on mclk
// Notes:   Core leaves STOP whenever it is held in reset
`timescale 1ns/1ns
module rsc_core_model (
	// Clock
	input  wire logic mclk,
	// From controller
	input  wire logic cpu_reset,
	input  wire logic reset_pin_o,
	input  wire logic reset_pin_oe_n,
	// From bench
	input  wire logic ext_low,
	input  wire logic stop_req,
	// To controller
	output logic      reset_pin_i,
	output logic      stop_mode
);
	// Pull-up, external switch and controller drive
	assign reset_pin_i = ~ext_low & (reset_pin_oe_n | reset_pin_o);
	initial stop_mode = 1'b0;
	// STOP on request, left when reset
	always @(posedge mclk) begin
		if (cpu_reset) begin
			stop_mode <= 1'b0;
		end else if (stop_req) begin
			stop_mode <= 1'b1;
		end
	end
endmodule // rsc_core_model

// ==== tb/rsc_top_tb.sv ====
// Purpose: Self-checking bench for the reset sequencer
// Assumes: One slave on the bus; hready follows hreadyout
// Notes:   Level sources restart counts, so they get bounds only
`timescale 1ns/1ns
module rsc_top_tb import rsc_pkg::*; ();
	logic              mclk, reset, hwrite, hready, hreadyout, hresp;
	logic [1:0]        htrans;
	logic [31:0]       haddr, hwdata, hrdata, rd;
	logic              por_det, brownout_low, wdt_timeout, fault_det;
	logic              ext_low, stop_req, stop_mode, wdt_opt, bo_opt;
	logic [GPIO_W-1:0] gpio_pin;
	logic              reset_pin_i, reset_pin_o, reset_pin_oe_n;
	logic [PWM_W-1:0]  pwm_off_option, pwm_off_level;
	logic              cpu_reset, periph_reset, debugger_reset;
	logic              option_load, sysclk_en, gpio_input_force, pwm_hiz;
	logic              pwm_drive_off, brownout_enable, fault0_in;
	logic              vector_fetch;
	logic [15:0]       vector_addr;
	int                n_fail, samples_checked, cyc, hi, k;
	logic [7:0]        causes [5] = '{8'h80, 8'h80, 8'h20, 8'h10, 8'h08};

	assign hready = hreadyout;
	always #50 mclk = ~mclk;

	rsc_top dut (.mclk(mclk), .reset(reset), .hsel(1'b1), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .por_det(por_det), .brownout_low(brownout_low),
		.wdt_timeout(wdt_timeout), .fault_det(fault_det),
		.gpio_pin(gpio_pin), .reset_pin_i(reset_pin_i),
		.reset_pin_o(reset_pin_o), .reset_pin_oe_n(reset_pin_oe_n),
		.stop_mode(stop_mode), .watchdog_reset_option(wdt_opt),
		.brownout_in_stop_option(bo_opt), .fltsel_option(1'b0),
		.pwm_off_option(pwm_off_option), .cpu_reset(cpu_reset),
		.periph_reset(periph_reset), .debugger_reset(debugger_reset),
		.option_load(option_load), .sysclk_en(sysclk_en),
		.gpio_input_force(gpio_input_force), .pwm_hiz(pwm_hiz),
		.pwm_drive_off(pwm_drive_off), .pwm_off_level(pwm_off_level),
		.brownout_enable(brownout_enable), .fault0_in(fault0_in),
		.vector_fetch(vector_fetch), .vector_addr(vector_addr));

	rsc_core_model partner (.mclk(mclk), .cpu_reset(cpu_reset),
		.reset_pin_o(reset_pin_o), .reset_pin_oe_n(reset_pin_oe_n),
		.ext_low(ext_low), .stop_req(stop_req),
		.reset_pin_i(reset_pin_i), .stop_mode(stop_mode));

	task complete_run;
		$display("n_fail=%0d samples_checked=%0d", n_fail, samples_checked);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task tick;
		@(posedge mclk);
		#1;
	endtask

	task ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		@(posedge mclk);
		htrans <= 2'h2;
		haddr  <= a;
		hwrite <= wr;
		do begin
			@(posedge mclk);
		end while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do begin
			@(posedge mclk);
		end while (hready !== 1'b1);
		rd = hrdata;
	endtask

	task rdchk(input logic [31:0] a, input logic [31:0] e);
		ahb(1'b0, a, 32'h0);
		check(rd, e);
	endtask

	task drive_src(input int src, input logic v);
		case (src)
			0: por_det <= v;
			1: brownout_low <= v;
			2: wdt_timeout <= v;
			3: ext_low <= v;
			4: fault_det <= v;
			5: gpio_pin <= v ? 8'h01 : 8'h00;
			default: gpio_pin <= v ? 8'h02 : 8'h00;
		endcase
	endtask

	task stir(input int src, input int n);
		@(posedge mclk);
		drive_src(src, 1'b1);
		repeat (n) @(posedge mclk);
		drive_src(src, 1'b0);
	endtask

	task quiet(input int n);
		int odd;
		odd = 0;
		repeat (n) begin
			tick();
			if (cpu_reset !== 1'b0) odd++;
		end
		check(odd, 0);
	endtask

	task to_stop;
		@(posedge mclk);
		stop_req <= 1'b1;
		@(posedge mclk);
		stop_req <= 1'b0;
		tick();
		tick();
	endtask

	task run_seq(input logic sys, input logic exact, input logic dbg);
		int ld, tl, odd, n;
		hi = 0; ld = 0; tl = 0; odd = 0; n = 0;
		while (cpu_reset !== 1'b1 && n < 200) begin
			tick();
			n++;
		end
		while (cpu_reset === 1'b1 && hi < 2000) begin
			hi++;
			if (option_load === 1'b1) ld++;
			else tl++;
			if (sys && (reset_pin_oe_n === option_load || gpio_input_force !== 1'b1
				|| pwm_hiz !== option_load || pwm_drive_off === option_load
				|| sysclk_en === option_load || debugger_reset !== dbg))
				odd++;
			if (periph_reset !== sys) odd++;
			tick();
		end
		check(hi >= 66, 1'b1);
		check(odd, 0);
		if (exact) check(ld, 50);
		if (exact) check(tl, 16);
		check(vector_fetch, 1'b1);
		check(vector_addr, 16'h0002);
	endtask

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			complete_run();
		end
	end

	initial begin
		mclk = 0; reset = 1; htrans = 0; haddr = 0; hwrite = 0; hwdata = 0;
		por_det = 0; brownout_low = 0; wdt_timeout = 0; fault_det = 0;
		ext_low = 0; stop_req = 0; wdt_opt = 1; bo_opt = 0; gpio_pin = 0;
		pwm_off_option = 6'h2A; n_fail = 0; samples_checked = 0; cyc = 0;
		repeat (16) @(posedge mclk);
		reset <= 1'b0;
		run_seq(1'b1, 1'b0, 1'b1);
		check(pwm_off_level, 6'h2A);
		check(brownout_enable, 1'b1);
		rdchk(32'h3FC0, 32'h80);
		rdchk(32'h8, 32'h0);
		ahb(1'b1, 32'h8, 32'hFF);
		rdchk(32'h8, 32'hFF);
		ahb(1'b1, 32'h100, 32'hFFFFFFFF);
		rdchk(32'h100, 32'h0);
		ahb(1'b1, 32'h8, 32'h1);
		for (k = 0; k < 5; k++) begin
			fork
				stir(k, 6);
				run_seq(1'b1, k == 2 || k == 4, 1'b1);
			join
			rdchk(32'h3FC0, causes[k]);
		end
		rdchk(32'h8, 32'h0);
		fork
			ahb(1'b1, 32'h4, 32'h1);
			run_seq(1'b1, 1'b1, 1'b0);
		join
		rdchk(32'h4, 32'h0);
		rdchk(32'h3FC0, 32'h80);
		@(posedge mclk);
		wdt_opt <= 1'b0;
		stir(2, 6);
		quiet(60);
		fork
			stir(1, 200);
			run_seq(1'b1, 1'b0, 1'b1);
		join
		check(hi >= 255, 1'b1);
		fork
			stir(3, 150);
			run_seq(1'b1, 1'b0, 1'b1);
		join
		check(hi >= 150 && hi <= 180, 1'b1);
		ahb(1'b1, 32'h8, 32'h1);
		to_stop();
		check(brownout_enable, 1'b0);
		@(posedge mclk);
		bo_opt <= 1'b1;
		tick();
		tick();
		check(brownout_enable, 1'b1);
		fork
			stir(2, 6);
			run_seq(1'b0, 1'b0, 1'b0);
		join
		rdchk(32'h3FC0, 32'h60);
		rdchk(32'h8, 32'h1);
		to_stop();
		stir(6, 6);
		quiet(60);
		fork
			stir(5, 6);
			run_seq(1'b0, 1'b0, 1'b0);
		join
		rdchk(32'h3FC0, 32'h40);
		ahb(1'b1, 32'h3FC0, 32'h1);
		rdchk(32'h3FC0, 32'h40);
		ahb(1'b1, 32'h3FC0, 32'h14);
		ahb(1'b1, 32'h3FC0, 32'h92);
		ahb(1'b1, 32'h3FC0, 32'h1);
		rdchk(32'h3FC0, 32'h41);
		@(posedge mclk);
		ext_low <= 1'b1;
		repeat (8) tick();
		check(fault0_in, 1'b1);
		quiet(40);
		complete_run();
	end
endmodule // rsc_top_tb
